// >>> fscr_pkg.sv
// Constants shared by the synthesizer configuration register bank
package fscr_pkg;
	localparam int WORD_W = 32;
	localparam int CODE_HI = 2;
	localparam int CODE_LO = 0;
	localparam logic [2:0] CODE_INT_FRACTIONAL_VALUE = 3'h0;
	localparam logic [2:0] CODE_LOWER = 3'h1;
	localparam logic [2:0] CODE_REF = 3'h2;
	localparam logic [2:0] CODE_FUNC = 3'h3;
	localparam logic [2:0] CODE_TEST = 3'h4;
	// Integer/fraction word
	localparam int MUX_HI = 30;
	localparam int MUX_LO = 27;
	localparam int INT_HI = 26;
	localparam int INT_LO = 15;
	localparam int FMSB_HI = 14;
	localparam int FMSB_LO = 3;
	// Lower fraction word
	localparam int FLSB_HI = 27;
	localparam int FLSB_LO = 15;
	// Reference divider word
	localparam int CSR_BIT = 28;
	localparam int CPI_HI = 27;
	localparam int CPI_LO = 24;
	localparam int PRESC_BIT = 22;
	localparam int HALF_BIT = 21;
	localparam int DBL_BIT = 20;
	localparam int RCNT_HI = 19;
	localparam int RCNT_LO = 15;
	// Function word
	localparam int SDRST_BIT = 14;
	localparam int LDP_BIT = 7;
	localparam int POL_BIT = 6;
	localparam int PD_BIT = 5;
	localparam int TRI_BIT = 4;
	localparam int CRST_BIT = 3;
	// Test word
	localparam int NB_HI = 24;
	localparam int NB_LO = 23;
	localparam logic [1:0] NB_ON = 2'h3;
	localparam int CDM_HI = 20;
	localparam int CDM_LO = 19;
	localparam logic [1:0] CDM_FAST = 2'h1;
	localparam int CDV_HI = 18;
	localparam int CDV_LO = 7;
	// Field widths, lock detect targets and the fastlock mux code
	localparam int FRACTIONAL_VALUE_LSB_W = 13;
	localparam int FRACTIONAL_VALUE_MSB_W = 12;
	localparam int RCNT_W = 5;
	localparam int CDV_W = 12;
	localparam int LOCK_W = 6;
	localparam logic [5:0] LOCK_CNT_COARSE = 6'h18;
	localparam logic [5:0] LOCK_CNT_FINE = 6'h28;
	localparam logic [3:0] MUX_FASTLOCK = 4'hc;
endpackage : fscr_pkg

// >>> fscr_shift_rx.sv
// Three-wire serial input shift register with latch strobe
`timescale 1ns/1ps
`default_nettype none
module fscr_shift_rx #(
	parameter int WORD_W = fscr_pkg::WORD_W
) (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic ce_in,
	input wire logic serial_clock_in,
	input wire logic serial_data_in,
	input wire logic latch_strobe_in,
	output logic [WORD_W-1:0] word_out,
	output logic word_valid_out
);
	typedef struct packed {
		logic [2:0] s1;
		logic [2:0] s2;
		logic [2:0] s3;
		logic [WORD_W-1:0] shift;
		logic [WORD_W-1:0] word;
		logic valid;
	} fscr_rx_t;

	fscr_rx_t st;
	fscr_rx_t next_st;

	always_comb begin
		next_st = st;
		next_st.s1 = {serial_clock_in, serial_data_in, latch_strobe_in};
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		next_st.valid = 1'b0;
		// Shift MSB first on each rising serial clock
		if (st.s2[2] && !st.s3[2]) begin
			next_st.shift = {st.shift[WORD_W-2:0], st.s2[1]};
		end
		// Hand the word over on the rising strobe edge
		if (st.s2[0] && !st.s3[0]) begin
			next_st.word = st.shift;
			next_st.valid = 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			st <= '0;
		end else if (ce_in) begin
			st <= next_st;
		end
	end

	assign word_out = st.word;
	assign word_valid_out = st.valid;
endmodule : fscr_shift_rx
`default_nettype wire

// >>> fscr_ref_path.sv
// Reference path: edge select, doubler, R counter and half divider
`timescale 1ns/1ps
`default_nettype none
module fscr_ref_path #(
	parameter int RCNT_W = fscr_pkg::RCNT_W
) (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic ce_in,
	input wire logic reference_input_in,
	input wire logic doubler_in,
	input wire logic half_in,
	input wire logic [RCNT_W-1:0] r_count_in,
	input wire logic hold_in,
	output logic pfd_tick_out
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic [RCNT_W-1:0] cnt;
		logic half;
		logic tick;
	} fscr_ref_t;

	fscr_ref_t st;
	fscr_ref_t next_st;
	logic ref_edge;

	// Falling edge only, or both edges with the doubler on
	assign ref_edge = doubler_in ? (st.s2 ^ st.s3) : (st.s3 & ~st.s2);

	always_comb begin
		next_st = st;
		next_st.s1 = reference_input_in;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		next_st.tick = 1'b0;
		if (hold_in) begin
			next_st.cnt = '0;
			next_st.half = 1'b0;
		end else if (ref_edge) begin
			// Count of zero divides by the full range
			if (st.cnt == r_count_in - {{(RCNT_W-1){1'b0}}, 1'b1}) begin
				next_st.cnt = '0;
				next_st.half = half_in ? ~st.half : 1'b0;
				next_st.tick = ~half_in | st.half;
			end else begin
				next_st.cnt = st.cnt + {{(RCNT_W-1){1'b0}}, 1'b1};
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			st <= '0;
		end else if (ce_in) begin
			st <= next_st;
		end
	end

	assign pfd_tick_out = st.tick;
endmodule : fscr_ref_path
`default_nettype wire

// >>> fscr_top.sv
// Configuration register bank of the fractional-N synthesizer
`timescale 1ns/1ps
`default_nettype none
module fscr_top (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic ce_in,
	input wire logic serial_clock_in,
	input wire logic serial_data_in,
	input wire logic latch_strobe_in,
	input wire logic reference_input_in,
	input wire logic phase_in_window_in,
	output logic [fscr_pkg::FRACTIONAL_VALUE_MSB_W-1:0] int_value_out,
	output logic [fscr_pkg::FRACTIONAL_VALUE_MSB_W+fscr_pkg::FRACTIONAL_VALUE_LSB_W-1:0] fractional_value_out,
	output logic [3:0] mux_select_out,
	output logic muxed_output_pin_out,
	output logic [3:0] cp_current_out,
	output logic slip_reduction_enable_out,
	output logic prescaler_high_out,
	output logic ref_half_divider_out,
	output logic doubler_out,
	output logic [fscr_pkg::RCNT_W-1:0] r_count_out,
	output logic lock_precision_select_out,
	output logic pd_polarity_out,
	output logic power_down_out,
	output logic cp_three_state_out,
	output logic counter_hold_out,
	output logic sdm_reset_out,
	output logic neg_bleed_out,
	output logic fastlock_switch_out,
	output logic lock_detect_out,
	output logic pfd_tick_out
);
	typedef struct packed {
		logic [fscr_pkg::WORD_W-1:0] int_fractional_value_word;
		logic [fscr_pkg::WORD_W-1:0] lower_word;
		logic [fscr_pkg::WORD_W-1:0] ref_word;
		logic [fscr_pkg::WORD_W-1:0] func_word;
		logic [fscr_pkg::WORD_W-1:0] test_word;
		logic [fscr_pkg::FRACTIONAL_VALUE_LSB_W-1:0] lower_active;
		logic [fscr_pkg::RCNT_W-1:0] rcnt_active;
		logic dbl_active;
		logic [3:0] cpi_active;
		logic sdm_reset;
		logic win1;
		logic win2;
		logic [fscr_pkg::LOCK_W-1:0] lock_cnt;
		logic lock;
		logic [fscr_pkg::CDV_W-1:0] fl_timer;
	} fscr_t;

	fscr_t st;
	fscr_t next_st;
	logic [fscr_pkg::WORD_W-1:0] rx_word;
	logic word_valid;
	logic [2:0] code;
	logic pfd_tick;
	logic power_down;
	logic hold;
	logic fast_mode;
	logic fast_load;
	logic [fscr_pkg::LOCK_W-1:0] lock_target;

	fscr_shift_rx #(
		.WORD_W(fscr_pkg::WORD_W)
	) u_rx (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.ce_in(ce_in),
		.serial_clock_in(serial_clock_in),
		.serial_data_in(serial_data_in),
		.latch_strobe_in(latch_strobe_in),
		.word_out(rx_word),
		.word_valid_out(word_valid)
	);

	fscr_ref_path #(
		.RCNT_W(fscr_pkg::RCNT_W)
	) u_ref (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.ce_in(ce_in),
		.reference_input_in(reference_input_in),
		.doubler_in(st.dbl_active),
		.half_in(st.ref_word[fscr_pkg::HALF_BIT]),
		.r_count_in(st.rcnt_active),
		.hold_in(hold),
		.pfd_tick_out(pfd_tick)
	);

	assign code = rx_word[fscr_pkg::CODE_HI:fscr_pkg::CODE_LO];
	assign power_down = st.func_word[fscr_pkg::PD_BIT];
	assign hold = power_down | st.func_word[fscr_pkg::CRST_BIT];
	assign fast_mode = st.test_word[fscr_pkg::CDM_HI:fscr_pkg::CDM_LO] == fscr_pkg::CDM_FAST;
	assign fast_load = word_valid && code == fscr_pkg::CODE_INT_FRACTIONAL_VALUE && fast_mode;
	assign lock_target = st.func_word[fscr_pkg::LDP_BIT] ? fscr_pkg::LOCK_CNT_FINE
		: fscr_pkg::LOCK_CNT_COARSE;

	always_comb begin
		next_st = st;
		next_st.sdm_reset = 1'b0;
		next_st.win1 = phase_in_window_in;
		next_st.win2 = st.win1;
		// Words are accepted in power-down too
		if (word_valid) begin
			if (code == fscr_pkg::CODE_INT_FRACTIONAL_VALUE) begin
				next_st.int_fractional_value_word = rx_word;
				// Buffered settings move to the active copies
				next_st.lower_active = st.lower_word[fscr_pkg::FLSB_HI:fscr_pkg::FLSB_LO];
				next_st.rcnt_active = st.ref_word[fscr_pkg::RCNT_HI:fscr_pkg::RCNT_LO];
				next_st.dbl_active = st.ref_word[fscr_pkg::DBL_BIT];
				next_st.cpi_active = st.ref_word[fscr_pkg::CPI_HI:fscr_pkg::CPI_LO];
				next_st.sdm_reset = ~st.func_word[fscr_pkg::SDRST_BIT];
			end else if (code == fscr_pkg::CODE_LOWER) begin
				next_st.lower_word = rx_word;
			end else if (code == fscr_pkg::CODE_REF) begin
				next_st.ref_word = rx_word;
			end else if (code == fscr_pkg::CODE_FUNC) begin
				next_st.func_word = rx_word;
			end else if (code == fscr_pkg::CODE_TEST) begin
				next_st.test_word = rx_word;
			end
		end
		// Lock detect counts consecutive in-window detector cycles
		if (power_down) begin
			next_st.lock_cnt = '0;
			next_st.lock = 1'b0;
		end else if (pfd_tick) begin
			if (!st.win2) begin
				next_st.lock_cnt = '0;
				next_st.lock = 1'b0;
			end else if (st.lock_cnt == lock_target - 6'h01) begin
				next_st.lock = 1'b1;
			end else if (!st.lock) begin
				next_st.lock_cnt = st.lock_cnt + 6'h01;
			end
		end
		// Fastlock timer runs in detector cycles
		if (power_down) begin
			next_st.fl_timer = '0;
		end else if (fast_load) begin
			next_st.fl_timer = st.test_word[fscr_pkg::CDV_HI:fscr_pkg::CDV_LO];
		end else if (pfd_tick && st.fl_timer != '0) begin
			next_st.fl_timer = st.fl_timer - 12'h001;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			st <= '0;
		end else if (ce_in) begin
			st <= next_st;
		end
	end

	assign int_value_out = st.int_fractional_value_word[fscr_pkg::INT_HI:fscr_pkg::INT_LO];
	assign fractional_value_out = {st.int_fractional_value_word[fscr_pkg::FMSB_HI:fscr_pkg::FMSB_LO],
		st.lower_active};
	assign mux_select_out = st.int_fractional_value_word[fscr_pkg::MUX_HI:fscr_pkg::MUX_LO];
	// Fastlock code pulls the pin low while wide bandwidth is active
	assign muxed_output_pin_out = (mux_select_out == fscr_pkg::MUX_FASTLOCK)
		? ~fastlock_switch_out : st.lock;
	assign cp_current_out = st.cpi_active;
	assign slip_reduction_enable_out = st.ref_word[fscr_pkg::CSR_BIT];
	assign prescaler_high_out = st.ref_word[fscr_pkg::PRESC_BIT];
	assign ref_half_divider_out = st.ref_word[fscr_pkg::HALF_BIT];
	assign doubler_out = st.dbl_active;
	assign r_count_out = st.rcnt_active;
	assign lock_precision_select_out = st.func_word[fscr_pkg::LDP_BIT];
	assign pd_polarity_out = st.func_word[fscr_pkg::POL_BIT];
	assign power_down_out = power_down;
	assign cp_three_state_out = power_down | st.func_word[fscr_pkg::TRI_BIT];
	assign counter_hold_out = hold;
	assign sdm_reset_out = st.sdm_reset;
	assign neg_bleed_out = st.test_word[fscr_pkg::NB_HI:fscr_pkg::NB_LO] == fscr_pkg::NB_ON;
	assign fastlock_switch_out = st.fl_timer != '0;
	assign lock_detect_out = st.lock;
	assign pfd_tick_out = pfd_tick;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);

	sequence s_r0_write;
		ce_in && word_valid && code == fscr_pkg::CODE_INT_FRACTIONAL_VALUE;
	endsequence
	sequence s_lower_write;
		ce_in && word_valid && code == fscr_pkg::CODE_LOWER;
	endsequence
	sequence s_ref_write;
		ce_in && word_valid && code == fscr_pkg::CODE_REF;
	endsequence
	sequence s_func_write;
		ce_in && word_valid && code == fscr_pkg::CODE_FUNC;
	endsequence
	sequence s_test_write;
		ce_in && word_valid && code == fscr_pkg::CODE_TEST;
	endsequence

	int_load_a: assert property (s_r0_write |=>
		int_value_out == $past(rx_word[fscr_pkg::INT_HI:fscr_pkg::INT_LO]))
		else $error("integer value not loaded");
	mux_load_a: assert property (s_r0_write |=>
		mux_select_out == $past(rx_word[fscr_pkg::MUX_HI:fscr_pkg::MUX_LO]))
		else $error("mux select not loaded");
	fractional_value_pair_a: assert property (s_r0_write |=>
		fractional_value_out == {$past(rx_word[fscr_pkg::FMSB_HI:fscr_pkg::FMSB_LO]),
		$past(st.lower_word[fscr_pkg::FLSB_HI:fscr_pkg::FLSB_LO])})
		else $error("fraction not formed from both words");
	lower_latch_a: assert property (s_lower_write |=>
		st.lower_word == $past(rx_word) && $stable(fractional_value_out))
		else $error("lower word not latched or applied early");
	ref_route_a: assert property (s_ref_write |=>
		st.ref_word == $past(rx_word) && $stable(st.func_word) && $stable(st.test_word))
		else $error("reference word misrouted");
	slip_bit_a: assert property (s_ref_write |=>
		slip_reduction_enable_out == $past(rx_word[fscr_pkg::CSR_BIT]))
		else $error("slip reduction bit wrong");
	cp_current_a: assert property (s_r0_write |=>
		cp_current_out == $past(st.ref_word[fscr_pkg::CPI_HI:fscr_pkg::CPI_LO]))
		else $error("charge pump current not applied");
	buffer_hold_a: assert property ((ce_in && word_valid && code != fscr_pkg::CODE_INT_FRACTIONAL_VALUE)
		|=> $stable(r_count_out) && $stable(doubler_out) && $stable(cp_current_out))
		else $error("buffered setting changed without integer write");
	sdm_reset_a: assert property (s_r0_write |=>
		sdm_reset_out == !$past(st.func_word[fscr_pkg::SDRST_BIT]))
		else $error("modulator reset wrong");
	lock_rise_a: assert property ($rose(lock_detect_out) |->
		$past(st.lock_cnt) == $past(lock_target) - 6'h01 && $past(st.win2) && $past(pfd_tick))
		else $error("lock set before enough cycles");
	pd_effect_a: assert property ((ce_in && power_down_out) |->
		(cp_three_state_out && counter_hold_out) ##1 (!lock_detect_out && !fastlock_switch_out))
		else $error("power-down effects missing");
	tristate_a: assert property (st.func_word[fscr_pkg::TRI_BIT] |-> cp_three_state_out)
		else $error("charge pump not three-stated");
	fast_count_a: assert property ((ce_in && pfd_tick && fastlock_switch_out && !fast_load
		&& !power_down_out) |=> st.fl_timer == $past(st.fl_timer) - 12'h001)
		else $error("fastlock timer did not count");
	func_route_a: assert property (s_func_write |=>
		st.func_word == $past(rx_word) && $stable(st.ref_word) && $stable(st.test_word))
		else $error("function word misrouted");
	test_route_a: assert property (s_test_write |=>
		st.test_word == $past(rx_word) && $stable(st.ref_word) && $stable(st.func_word))
		else $error("test word misrouted");
	code_refuse_a: assert property ((ce_in && word_valid
		&& code > fscr_pkg::CODE_TEST) |=> $stable(st.int_fractional_value_word)
		&& $stable(st.lower_word) && $stable(st.ref_word) && $stable(st.func_word)
		&& $stable(st.test_word))
		else $error("unused code changed a register");
	pin_fast_a: assert property ((mux_select_out == fscr_pkg::MUX_FASTLOCK) |->
		muxed_output_pin_out == !fastlock_switch_out)
		else $error("muxed pin not following fastlock switch");
	neg_bleed_a: assert property (s_test_write |=> neg_bleed_out ==
		($past(rx_word[fscr_pkg::NB_HI:fscr_pkg::NB_LO]) == fscr_pkg::NB_ON))
		else $error("negative bleed setting wrong");
	fast_load_a: assert property ((ce_in && fast_load && !power_down_out) |=>
		st.fl_timer == $past(st.test_word[fscr_pkg::CDV_HI:fscr_pkg::CDV_LO]))
		else $error("fastlock timer not loaded");
	half_bit_a: assert property (s_ref_write |=>
		ref_half_divider_out == $past(rx_word[fscr_pkg::HALF_BIT]))
		else $error("half divider bit wrong");
	polarity_bit_a: assert property (s_func_write |=>
		pd_polarity_out == $past(rx_word[fscr_pkg::POL_BIT]))
		else $error("detector polarity bit wrong");
	pd_retain_a: assert property ((ce_in && power_down_out && !word_valid) |=>
		$stable(st.int_fractional_value_word) && $stable(st.ref_word) && $stable(st.func_word))
		else $error("register lost in power-down");
	counter_hold_a: assert property (st.func_word[fscr_pkg::CRST_BIT] |->
		counter_hold_out)
		else $error("counters not held");
	lock_clear_a: assert property ((ce_in && pfd_tick && !st.win2) |=>
		!lock_detect_out)
		else $error("lock kept after out-of-window cycle");
	sdm_pulse_a: assert property ((ce_in && sdm_reset_out) |=> !sdm_reset_out)
		else $error("modulator reset longer than one cycle");
endmodule : fscr_top
`default_nettype wire

// >>> fscr_host_model.sv
// Host-side model that writes words over the three-wire serial link
`timescale 1ns/1ps
`default_nettype none
module fscr_host_model (
	input wire logic clk_in,
	output logic serial_clock_out,
	output logic serial_data_out,
	output logic latch_strobe_out
);
	initial begin
		serial_clock_out = 1'b0;
		serial_data_out = 1'b0;
		latch_strobe_out = 1'b0;
	end
	// Shift one word, hp clocks per serial half period (3 at the least)
	task automatic write_word(input logic [31:0] w, input int hp);
		for (int i = 31; i >= 0; i--) begin
			@(posedge clk_in);
			#1 serial_clock_out = 1'b0;
			serial_data_out = w[i];
			repeat (hp) @(posedge clk_in);
			#1 serial_clock_out = 1'b1;
			repeat (hp) @(posedge clk_in);
		end
		#1 latch_strobe_out = 1'b1;
		repeat (hp) @(posedge clk_in);
		#1 latch_strobe_out = 1'b0;
		serial_clock_out = 1'b0;
		serial_data_out = ~w[0];
	endtask : write_word
endmodule : fscr_host_model
`default_nettype wire

// >>> tb_fscr_top.sv
// Self-checking bench for the synthesizer configuration register bank
`timescale 1ns/1ps
`default_nettype none
module tb_fscr_top;
	logic clk_in, reset_in, ce_in, reference_input_in, phase_in_window_in;
	logic sclk, sdata, strobe;
	logic [11:0] int_value_out;
	logic [24:0] fractional_value_out;
	logic [3:0] mux_select_out, cp_current_out;
	logic [4:0] r_count_out;
	logic muxed_output_pin_out, slip_reduction_enable_out, prescaler_high_out;
	logic ref_half_divider_out, doubler_out, lock_precision_select_out, pd_polarity_out;
	logic power_down_out, cp_three_state_out, counter_hold_out, sdm_reset_out;
	logic neg_bleed_out, fastlock_switch_out, lock_detect_out, pfd_tick_out;
	logic [31:0] w [0:4];
	logic [31:0] act_lo, act_ref;
	int n_fail, compares, n_sdm, n_tick, n_act, n0, seed;
	int tq[$];
	int rv[4] = '{3, 5, 2, 0};
	int dv[4] = '{0, 1, 0, 0};
	int hv[4] = '{0, 0, 1, 0};
	int ev[4] = '{3, 5, 4, 32};

	fscr_host_model host_i (.clk_in, .serial_clock_out(sclk), .serial_data_out(sdata),
		.latch_strobe_out(strobe));
	fscr_top fscr_top_i (.clk_in, .reset_in, .ce_in, .serial_clock_in(sclk),
		.serial_data_in(sdata), .latch_strobe_in(strobe), .reference_input_in,
		.phase_in_window_in, .int_value_out, .fractional_value_out, .mux_select_out,
		.muxed_output_pin_out, .cp_current_out, .slip_reduction_enable_out,
		.prescaler_high_out, .ref_half_divider_out, .doubler_out, .r_count_out,
		.lock_precision_select_out, .pd_polarity_out, .power_down_out,
		.cp_three_state_out, .counter_hold_out, .sdm_reset_out, .neg_bleed_out,
		.fastlock_switch_out, .lock_detect_out, .pfd_tick_out);

	initial begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end

	// Count modulator reset pulses and detector ticks, stamping each tick
	always @(posedge clk_in) begin
		if (sdm_reset_out === 1'b1) n_sdm++;
		if (pfd_tick_out === 1'b1) begin
			n_tick++;
			tq.push_back(n_act);
		end
	end

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : summarize

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic check_all();
		chk("int", w[0][26:15], int_value_out);
		chk("fractional_value", {w[0][14:3], act_lo[27:15]}, fractional_value_out);
		chk("mux", w[0][30:27], mux_select_out);
		chk("cp", act_ref[27:24], cp_current_out);
		chk("csr", w[2][28], slip_reduction_enable_out);
		chk("presc", w[2][22], prescaler_high_out);
		chk("half", w[2][21], ref_half_divider_out);
		chk("dbl", act_ref[20], doubler_out);
		chk("rcnt", act_ref[19:15], r_count_out);
		chk("ldp", w[3][7], lock_precision_select_out);
		chk("pol", w[3][6], pd_polarity_out);
		chk("pd", w[3][5], power_down_out);
		chk("tri", w[3][5] | w[3][4], cp_three_state_out);
		chk("hold", w[3][5] | w[3][3], counter_hold_out);
		chk("bleed", w[4][24:23] == 2'h3, neg_bleed_out);
	endtask : check_all

	// Write one word, update the shadow model and compare every field except the test word CDM and CDV fields
	task automatic wr(input logic [31:0] v);
		int s;
		s = n_sdm;
		host_i.write_word(v, v[3] ? 6 : 3);
		if (v[2:0] <= 3'h4) w[v[2:0]] = v;
		if (v[2:0] == 3'h0) begin
			act_lo = w[1];
			act_ref = w[2];
		end
		repeat (8) @(posedge clk_in);
		chk("sdm", (v[2:0] == 3'h0 && !w[3][14]) ? 1 : 0, n_sdm - s);
		check_all();
	endtask : wr

	// Random legal word for codes 0 to 4 with reserved positions kept zero; codes 5 to 7 get random upper bits
	function automatic logic [31:0] gen(input logic [2:0] c);
		logic [31:0] r;
		r = $urandom;
		case (c)
			3'h0: gen = {1'b0, r[30:27], 12'(75 + $urandom % 4021), r[14:3], c};
			3'h1: gen = {4'h0, r[27:15], 12'h0, c};
			3'h2: gen = {3'h0, r[28] & w[3][6], r[27:24], 1'b0, r[22:15], 12'h0, c};
			3'h3: gen = {17'h0, r[14], 6'h0, r[7:3], c};
			3'h4: gen = {7'h0, r[24:23], 4'h0, r[18:7], 4'h0, c};
			default: gen = {r[31:3], c};
		endcase
	endfunction : gen

	task automatic ref_edges(input int n);
		repeat (n) begin
			@(posedge clk_in);
			#1 reference_input_in = ~reference_input_in;
			if (act_ref[20] || !reference_input_in) n_act++;
			repeat (5) @(posedge clk_in);
		end
	endtask : ref_edges

	initial begin
		reset_in = 1'b1;
		ce_in = 1'b1;
		reference_input_in = 1'b1;
		phase_in_window_in = 1'b0;
		w = '{default: '0};
		act_lo = '0;
		act_ref = '0;
		seed = $urandom(32349);
		repeat (12) @(posedge clk_in);
		#1 reset_in = 1'b0;
		check_all();
		for (int c = 4; c >= 0; c--) wr(gen(3'(c)));
		repeat (30) wr(gen(3'($urandom)));
		wr(32'h0000_0023);
		wr(gen(3'h0));
		$display("test register writes done");
		wr(32'h0000_0003);
		#1 ce_in = 1'b0;
		host_i.write_word(gen(3'h2), 3);
		repeat (8) @(posedge clk_in);
		check_all();
		#1 ce_in = 1'b1;
		$display("test clock enable done");
		for (int k = 0; k < 4; k++) begin
			wr({10'h0, hv[k][0], dv[k][0], rv[k][4:0], 12'h0, 3'h2});
			wr(32'h0032_0000);
			tq.delete();
			for (int t = 0; t < 400 && tq.size() < 3; t++) ref_edges(1);
			if (tq.size() < 3) begin
				chk("tick count", 3, tq.size());
				summarize();
			end
			chk("tick spacing", ev[k], tq[2] - tq[1]);
		end
		$display("test reference path done");
		wr({12'h0, 5'h1, 12'h0, 3'h2});
		wr(32'h0032_0000);
		#1 phase_in_window_in = 1'b1;
		for (int k = 0; k < 2; k++) begin
			wr({24'h0, k[0], 2'h1, 5'h3});
			chk("lock pd", 1'b0, lock_detect_out);
			wr({24'h0, k[0], 7'h3});
			n0 = n_tick;
			for (int t = 0; t < 200 && lock_detect_out !== 1'b1; t++) ref_edges(1);
			chk("lock ticks", k ? 40 : 24, n_tick - n0);
			chk("pin lock", 1'b1, muxed_output_pin_out);
		end
		#1 phase_in_window_in = 1'b0;
		ref_edges(6);
		chk("lock clear", 1'b0, lock_detect_out);
		$display("test lock detect done");
		wr(32'h0188_0284);
		wr(32'h6032_0000);
		chk("fast on", 1'b1, fastlock_switch_out);
		chk("pin fast", 1'b0, muxed_output_pin_out);
		n0 = n_tick;
		for (int t = 0; t < 100 && fastlock_switch_out !== 1'b0; t++) ref_edges(1);
		chk("fast ticks", 5, n_tick - n0);
		chk("pin idle", 1'b1, muxed_output_pin_out);
		$display("test fastlock done");
		summarize();
	end
endmodule : tb_fscr_top
`default_nettype wire
